// ---- dv/atpmt_core_test.sv ----
// self-checking testbench for the avalon to pci master translator
`timescale 1ns/10ps
module atpmt_core_test;
  import atpmt_pkg::*;
  logic           mclk_i = 1'b0;
  logic           rst_i = 1'b1;
  atpmt_avm_req_t avm_req = '0;
  logic           wait_o, rdv_o;
  logic [63:0]    rdata_o;
  atpmt_pci_req_t pci_req;
  atpmt_pci_rsp_t pci_rsp;
  logic [7:0]     reg_addr = 8'h00;
  logic [31:0]    reg_wdata = 32'h0, reg_rdata;
  logic           reg_we = 1'b0, reg_re = 1'b0, slow = 1'b0, abrt = 1'b0;
  int             failures = 0, checks_done = 0, pc = 0, starts = 0, s0;
  logic [45:0]    phq[$];        // expected phases {cmd,req64_n,be,wchk,dword}
  logic [65:0]    rdq[$];        // expected beats {lane mask,data}
  logic [45:0]    pe, pg;
  logic [65:0]    re, rg;
  logic [63:0]    wd;
  always #5 mclk_i = ~mclk_i;
  atpmt_core #(.DATA64(1'b1), .MULTI_READ(1'b0), .FIXED_XLATE(1'b0), .PAGE_BITS(12)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .avm_req_i(avm_req), .avm_waitrequest_o(wait_o),
    .avm_readdata_o(rdata_o), .avm_readdatavalid_o(rdv_o), .pci_req_o(pci_req),
    .pci_rsp_i(pci_rsp), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(reg_rdata));
  atpmt_pci_target_model far (.mclk_i(mclk_i), .rst_i(rst_i), .pci_req_i(pci_req),
    .slow_i(slow), .abort_i(abrt), .pci_rsp_o(pci_rsp));
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [65:0] g, input logic [65:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // expected phase; narrow enables are folded onto one nibble
  task automatic ph(input logic [3:0] c, input logic r, input logic [7:0] b, input logic w,
                    input logic [31:0] d);
    phq.push_back({c, r, b, w, d});
    pc++;
  endtask : ph
  // expected beat from the last noted phase
  task automatic rx(input logic [1:0] m);
    logic [31:0] p;
    p = 32'h5A00_0000 + pc - 1;
    rdq.push_back({m, m == 2'b11 ? ~p : (m[1] ? p : 32'h0), m[0] ? p : 32'h0});
  endtask : rx
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr <= a; reg_wdata <= d; reg_we <= 1'b1;
    @(posedge mclk_i);
    reg_we <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_addr <= a; reg_re <= 1'b1;
    @(posedge mclk_i);
    reg_re <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : reg_rd
  // request held until the read command or every write beat is taken with waitrequest low
  task automatic avm(input logic rd, input logic [31:0] a, input logic [7:0] bc, be,
                     input logic [63:0] d);
    int n, t;
    logic w;
    @(posedge mclk_i);
    avm_req <= '{read: rd, write: !rd, addr: a, burst: bc, be: be, wdata: d};
    n = 0; t = 0;
    while (n < (rd ? 1 : int'(bc))) begin
      @(negedge mclk_i);
      w = wait_o;
      @(posedge mclk_i);
      if (w === 1'b0) n++;
      if (++t > 500) begin failures++; finish_test(); end
    end
    avm_req.read <= 1'b0; avm_req.write <= 1'b0;
  endtask : avm
  task automatic drain();
    int t;
    t = 0;
    while (phq.size() + rdq.size() > 0) begin
      @(posedge mclk_i);
      if (++t > 2000) begin failures++; finish_test(); end
    end
    repeat (3) @(posedge mclk_i);
  endtask : drain
  // watcher: each completed phase and beat is matched to the oldest note
  always @(posedge mclk_i) begin
    if (!rst_i && pci_req.start) starts++;
    if (!rst_i && pci_req.dval && pci_rsp.phase) begin
      pe = phq.size() ? phq.pop_front() : '1;
      pg = {pe[45:42] == 4'hF ? 4'hF : pci_req.cmd, pci_req.req64_n,
            pci_req.req64_n ? {4'h0, pci_req.be[7:4] | pci_req.be[3:0]} : pci_req.be,
            pe[32], pe[32] ? pci_req.wdata[31:0] : 32'h0};
      chk({20'h0, pg}, {20'h0, pe});
    end
    if (!rst_i && rdv_o) begin
      re = rdq.size() ? rdq.pop_front() : '1;
      rg = {re[65:64], re[65] ? rdata_o[63:32] : 32'h0, re[64] ? rdata_o[31:0] : 32'h0};
      chk(rg, re);
    end
  end
  initial begin
    void'($urandom(32'h2e16));
    wd = {$urandom, $urandom};
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    reg_rd(REG_CTRL, {24'h0, CLS_RST});
    reg_rd(REG_STAT, 32'h0);
    reg_rd(8'h40, 32'h0);
    // burst crossing a translation page becomes two transactions
    for (int i = 0; i < 2; i++) begin ph(4'hF, 1'b0, 8'hFF, 1'b0, 32'h0); rx(2'b11); end
    s0 = starts;
    avm(1'b1, 32'h0000_0FF8, 8'h02, 8'hFF, 64'h0);
    drain();
    chk(starts - s0, 2);
    ph(CMD_MRD, 1'b1, 8'h0F, 1'b0, 32'h0); rx(2'b01);
    avm(1'b1, 32'h0000_0100, 8'h01, 8'h0F, 64'h0);
    ph(CMD_MWR, 1'b1, 8'h0F, 1'b1, wd[63:32]);
    avm(1'b0, 32'h0000_0108, 8'h01, 8'hF0, wd);
    drain();
    slow <= 1'b1;
    ph(CMD_MWR, 1'b1, 8'h0C, 1'b1, wd[31:0]); ph(CMD_MWR, 1'b1, 8'h03, 1'b1, wd[63:32]);
    avm(1'b0, 32'h0000_0110, 8'h01, 8'h3C, wd);
    reg_rd(REG_STAT, 32'h1);
    drain();
    slow <= 1'b0;
    reg_rd(REG_STAT, 32'h0);
    ph(CMD_MRD, 1'b0, 8'hFF, 1'b0, 32'h0); rx(2'b11);
    avm(1'b1, 32'h0000_0118, 8'h01, 8'hFF, 64'h0);
    for (int i = 0; i < 8; i++) begin ph(CMD_MRM, 1'b0, 8'hFF, 1'b0, 32'h0); rx(2'b11); end
    avm(1'b1, 32'h0000_0200, 8'h08, 8'h5A, 64'h0);
    drain();
    reg_wr(REG_CTRL, 32'h10);
    for (int i = 0; i < 8; i++) begin ph(CMD_MRD, 1'b0, 8'hFF, 1'b0, 32'h0); rx(2'b11); end
    avm(1'b1, 32'h0000_0200, 8'h08, 8'hFF, 64'h0);
    for (int i = 0; i < 2; i++) ph(CMD_MWR, 1'b0, 8'h3C, 1'b0, 32'h0);
    avm(1'b0, 32'h0000_0300, 8'h02, 8'h3C, wd);
    drain();
    reg_wr(8'h14, 32'h0000_1001);
    reg_wr(8'h18, 32'h0000_2002);
    ph(CMD_IORD, 1'b1, 8'h0F, 1'b0, 32'h0); rx(2'b01);
    avm(1'b1, 32'h0000_1000, 8'h01, 8'h0F, 64'h0);
    ph(CMD_CFGWR, 1'b1, 8'h0F, 1'b1, wd[31:0]);
    avm(1'b0, 32'h0000_2000, 8'h01, 8'h0F, wd);
    for (int i = 0; i < 2; i++) begin ph(CMD_CFGRD, 1'b0, 8'hFF, 1'b0, 32'h0); rx(2'b11); end
    avm(1'b1, 32'h0000_2000, 8'h02, 8'hFF, 64'h0);
    drain();
    // target abort: sticky flag, cleared by writing one
    abrt <= 1'b1;
    rdq.push_back(66'h0);
    avm(1'b1, 32'h0000_0100, 8'h01, 8'h0F, 64'h0);
    drain();
    abrt <= 1'b0;
    reg_rd(REG_STAT, 32'h4);
    reg_wr(REG_STAT, 32'h4);
    reg_rd(REG_STAT, 32'h0);
    finish_test();
  end
endmodule : atpmt_core_test

// ---- dv/atpmt_pci_target_model.sv ----
// pci target model that answers the bridge's data phases
`timescale 1ns/10ps
module atpmt_pci_target_model
  import atpmt_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           rst_i,
  input  wire atpmt_pci_req_t pci_req_i,
  input  wire logic           slow_i,    // long wait states before each answer
  input  wire logic           abort_i,   // answer with an abort instead of a phase
  output atpmt_pci_rsp_t      pci_rsp_o
);
  logic [4:0]  cnt_ff;  // wait states spent on the offered phase
  logic [4:0]  lim_ff;  // wait states chosen for the offered phase
  logic [31:0] nph_ff;  // completed phases, seeds the read data
  logic [31:0] last_ff; // last dword put on the lanes
  logic        due;     // the answer falls in this cycle
  logic [31:0] pat;     // dword for the current phase
  assign due = pci_req_i.dval && (cnt_ff == lim_ff);
  assign pat = 32'h5A00_0000 + nph_ff;
  // 64-bit capable target; lanes outside a phase show the inverse of the last value, a 32-bit phase copies its dword to both halves
  always_comb begin
    pci_rsp_o.phase   = due && !abort_i;
    pci_rsp_o.abort   = due && abort_i;
    pci_rsp_o.stop    = 1'b0;
    pci_rsp_o.ack64_n = pci_req_i.req64_n;
    pci_rsp_o.rdata   = {~last_ff, ~last_ff};
    if (pci_rsp_o.phase) begin
      pci_rsp_o.rdata = pci_req_i.req64_n ? {pat, pat} : {~pat, pat};
    end
  end
  // wait-state counter; a fresh wait is drawn after every answer, random 0 to 3, or 12 when slow
  always @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_ff  <= 5'h00;
      lim_ff  <= 5'h00;
      nph_ff  <= 32'h0;
      last_ff <= 32'h0;
    end else if (due) begin
      cnt_ff <= 5'h00;
      lim_ff <= slow_i ? 5'h0C : 5'($urandom % 4);
      if (!abort_i) begin
        nph_ff  <= nph_ff + 32'h1;
        last_ff <= pat;
      end
    end else if (pci_req_i.dval) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end
endmodule : atpmt_pci_target_model

// ---- hdl/atpmt_core.sv ----
// avalon burst slave that initiates pci master transactions
//
// Overview of operation
// - avalon reads and writes become pci master transactions
// - progress and errors readable in status registers
// - space from translation, only command differs
// - configuration bursts are attempted like others
// - translation fixed or loaded by software
// - memory burst read over cache line uses read multiple
// - status flag set while a write pends
// - single mode: one delayed read at once
// - multi mode: at most four delayed reads
// - pci burst length follows avalon burst for reads; a write opens one transaction per beat
// - burst counts up to 128 supported
// - any alignment; split at translation page boundary
// - 32-bit single beat: one phase, same enables
// - 32-bit burst read: all enables on
// - 32-bit burst write: enables copied per phase
// - 64-bit lower-half single: one 32-bit phase
// - 64-bit upper-half single: odd dword phase
// - 64-bit full single read: try 64, resume upper
// - 64-bit full single write: two 32-bit phases
// - 64-bit burst read: 64 wide, odd resume 32
// - 64-bit burst write: realign single then retry
`timescale 1ns/10ps
module atpmt_core
  import atpmt_pkg::*;
#(
  parameter bit DATA64      = 1'b1, // 64-bit pci data path
  parameter bit MULTI_READ  = 1'b0, // multiple pending reads option
  parameter bit FIXED_XLATE = 1'b0, // translation fixed at build time
  parameter int PAGE_BITS   = 12    // translation page size in address bits
) (
  input  wire logic           mclk_i,
  input  wire logic           rst_i,
  input  wire atpmt_avm_req_t avm_req_i,
  output logic                avm_waitrequest_o,
  output logic [63:0]         avm_readdata_o,
  output logic                avm_readdatavalid_o,
  output atpmt_pci_req_t      pci_req_o,
  input  wire atpmt_pci_rsp_t pci_rsp_i,
  input  wire logic [7:0]     reg_addr_i,
  input  wire logic [31:0]    reg_wdata_i,
  input  wire logic           reg_we_i,
  input  wire logic           reg_re_i,
  output logic [31:0]         reg_rdata_o
);
  localparam int NPAGE = 4; // translation entries
  localparam logic [31:0] BPB = DATA64 ? 32'h8 : 32'h4; // bytes per beat
  localparam logic [2:0] PLIM = MULTI_READ ? MULTI_LIM : SINGLE_LIM;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001, // waiting for a command
    ST_LOADW = 4'b0010, // taking one write beat
    ST_START = 4'b0100, // opening a pci transaction
    ST_DATA  = 4'b1000  // offering data phases
  } atpmt_state_t;

  typedef struct packed {
    logic [31:PAGE_BITS] base; // pci address bits above the page
    logic [1:0]          sp;   // address space
  } atpmt_xlat_t;

  // request state
  atpmt_state_t state_ff, nxt_state;
  logic [31:0]  addr_ff, nxt_addr;       // byte address of next phase
  logic [31:0]  end_ff, nxt_end;         // byte address after last phase
  logic         isw_ff, nxt_isw;         // request is a write
  logic         multi_ff, nxt_multi;     // burst count above one
  logic         span_ff, nxt_span;       // covers more than a cache line
  logic         both_ff, nxt_both;       // avalon enables cover both halves
  logic [7:0]   be_ff, nxt_be;           // avalon byte enables
  logic         f32_ff, nxt_f32;         // read burst fell back to 32 bits
  logic         realign_ff, nxt_realign; // next write is one realign phase
  logic [63:0]  wbeat_ff, nxt_wbeat;     // write beat in flight
  logic [63:0]  rbeat_ff, nxt_rbeat;     // read beat being assembled
  logic         rval_ff, nxt_rval;       // read beat complete
  logic         req64n_ff, nxt_req64n;   // width asked for this transaction
  // status and control
  logic [7:0]   cls_ff, nxt_cls;
  logic         wpend_ff, nxt_wpend;
  logic         abort_ff, nxt_abort;
  logic [2:0]   pend_ff, nxt_pend;
  logic [31:0]  rdata_ff, nxt_rdata;
  atpmt_xlat_t  tbl_ff [NPAGE];
  atpmt_xlat_t  nxt_tbl [NPAGE];

  // helpers
  atpmt_xlat_t  xl;     // translation of the current address
  logic         wide;   // completed phase moved 64 bits
  logic [31:0]  step;   // next phase address
  logic         bdone;  // phase closed an avalon beat
  logic         rdone;  // phase closed the request
  logic         pgend;  // next phase starts a new page
  logic [31:0]  span_b; // request length in bytes

  // page index of an address, used for the translation lookup
  function automatic logic [1:0] pidx(input logic [31:0] a);
    pidx = a[PAGE_BITS+1 -: 2];
  endfunction : pidx

  // fixed translation maps straight through to memory space
  always_comb begin
    if (FIXED_XLATE) begin
      xl = '{base: addr_ff[31:PAGE_BITS], sp: SP_MEM};
    end else begin
      xl = tbl_ff[pidx(addr_ff)];
    end
  end

  // phase bookkeeping, all on the dword grid
  always_comb begin
    wide   = DATA64 && !req64n_ff && !pci_rsp_i.ack64_n;
    step   = addr_ff + (wide ? 32'h8 : 32'h4);
    rdone  = (step >= end_ff);
    bdone  = !DATA64 || (step[2:0] == 3'h0) || rdone;
    pgend  = (step[PAGE_BITS-1:0] == '0);
    span_b = {16'h0, 8'h0, avm_req_i.burst} * BPB;
  end

  // pci request outputs; all but last are a decoded view of registered state, last also follows ack64_n through pgend
  always_comb begin
    pci_req_o.start   = (state_ff == ST_START);
    pci_req_o.addr    = {xl.base, addr_ff[PAGE_BITS-1:0]};
    pci_req_o.req64_n = req64n_ff;
    pci_req_o.dval    = (state_ff == ST_DATA);
    // a burst ends at its count, at a page edge, or after a realign phase
    pci_req_o.last    = (addr_ff + (req64n_ff ? 32'h4 : 32'h8) >= end_ff)
                        || pgend || realign_ff;
    // command from space, only the code differs between spaces
    case (xl.sp)
      SP_IO:   pci_req_o.cmd = isw_ff ? CMD_IOWR : CMD_IORD;
      SP_CFG:  pci_req_o.cmd = isw_ff ? CMD_CFGWR : CMD_CFGRD;
      default: begin
        if (isw_ff) begin
          pci_req_o.cmd = CMD_MWR;
        end else begin
          pci_req_o.cmd = (multi_ff && span_ff) ? CMD_MRM : CMD_MRD;
        end
      end
    endcase
    // byte enables: reads of bursts take whole words, else copy avalon
    if (!isw_ff && multi_ff) begin
      pci_req_o.be = 8'hFF;
    end else if (!req64n_ff) begin
      pci_req_o.be = be_ff;
    end else if (DATA64 && addr_ff[2]) begin
      pci_req_o.be = {4'h0, be_ff[7:4]};
    end else begin
      pci_req_o.be = {4'h0, be_ff[3:0]};
    end
    // a 32-bit phase carries its dword on the lower lanes
    if (!req64n_ff || !DATA64) begin
      pci_req_o.wdata = wbeat_ff;
    end else begin
      pci_req_o.wdata = {wbeat_ff[63:32],
                         addr_ff[2] ? wbeat_ff[63:32] : wbeat_ff[31:0]};
    end
  end

  // main sequencer, next values
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_end = end_ff;
    nxt_isw = isw_ff;
    nxt_multi = multi_ff;
    nxt_span = span_ff;
    nxt_both = both_ff;
    nxt_be = be_ff;
    nxt_f32 = f32_ff;
    nxt_realign = realign_ff;
    nxt_wbeat = wbeat_ff;
    nxt_rbeat = rbeat_ff;
    nxt_rval = 1'b0;
    nxt_req64n = req64n_ff;
    nxt_wpend = wpend_ff;
    nxt_pend = pend_ff;
    avm_waitrequest_o = 1'b1;
    case (state_ff)
      ST_IDLE: begin
        // a read waits while the delayed read budget is spent
        if (avm_req_i.write || (avm_req_i.read && pend_ff < PLIM)) begin
          nxt_isw   = avm_req_i.write;
          nxt_multi = (avm_req_i.burst > 8'h1);
          nxt_span  = span_b > {22'h0, cls_ff, 2'h0};
          nxt_be    = DATA64 ? avm_req_i.be : {4'h0, avm_req_i.be[3:0]};
          nxt_both  = DATA64 && (avm_req_i.be[7:4] != 4'h0)
                      && (avm_req_i.be[3:0] != 4'h0);
          nxt_f32   = 1'b0;
          nxt_realign = 1'b0;
          // any start alignment; single-half beats shrink to one dword
          nxt_addr  = {avm_req_i.addr[31:3], 3'h0} & ~(DATA64 ? 32'h0 : 32'h4);
          if (!DATA64) begin
            nxt_addr = {avm_req_i.addr[31:2], 2'h0};
          end
          // counts above the supported maximum are clipped
          nxt_end = nxt_addr + ((avm_req_i.burst > MAX_BURST) ?
                    {24'h0, MAX_BURST} : {24'h0, avm_req_i.burst}) * BPB;
          if (DATA64 && avm_req_i.burst == 8'h1) begin
            if (avm_req_i.be[7:4] == 4'h0) begin
              nxt_end = nxt_addr + 32'h4;
            end else if (avm_req_i.be[3:0] == 4'h0) begin
              nxt_addr = nxt_addr + 32'h4;
            end
          end
          if (avm_req_i.write) begin
            nxt_wpend = 1'b1;
            nxt_state = ST_LOADW;
          end else begin
            nxt_pend  = pend_ff + 3'h1;
            avm_waitrequest_o = 1'b0; // read command is taken now
            nxt_state = ST_START;
          end
        end
      end
      ST_LOADW: begin
        // every write beat is taken just before its phases are offered
        avm_waitrequest_o = 1'b0;
        nxt_wbeat = avm_req_i.wdata;
        nxt_be    = DATA64 ? avm_req_i.be : {4'h0, avm_req_i.be[3:0]};
        nxt_state = ST_START;
      end
      ST_START: begin
        // 64-bit phases only from an even dword
        nxt_req64n = 1'b1;
        if (DATA64 && !addr_ff[2] && !f32_ff && !realign_ff) begin
          if (isw_ff) begin
            nxt_req64n = !multi_ff;
          end else begin
            nxt_req64n = !(multi_ff || both_ff);
          end
        end
        nxt_state = ST_DATA;
      end
      ST_DATA: begin
        if (pci_rsp_i.abort) begin
          // give a read one answer beat so a single read never hangs
          nxt_rval  = !isw_ff;
          nxt_wpend = 1'b0;
          nxt_pend  = isw_ff ? pend_ff : pend_ff - 3'h1;
          nxt_state = ST_IDLE;
        end else if (pci_rsp_i.phase) begin
          nxt_addr = step;
          nxt_realign = 1'b0;
          // place the read dword into its half of the beat
          if (wide || !DATA64) begin
            nxt_rbeat = pci_rsp_i.rdata;
          end else if (addr_ff[2]) begin
            nxt_rbeat = {pci_rsp_i.rdata[31:0], rbeat_ff[31:0]};
          end else begin
            nxt_rbeat = {rbeat_ff[63:32], pci_rsp_i.rdata[31:0]};
          end
          nxt_rval = !isw_ff && bdone;
          if (rdone) begin
            nxt_wpend = 1'b0;
            nxt_pend  = isw_ff ? pend_ff : pend_ff - 3'h1;
            nxt_state = ST_IDLE;
          end else if (pci_rsp_i.stop || pci_req_o.last) begin
            // disconnect on an odd dword by a 32-bit target
            if (step[2] && multi_ff && DATA64) begin
              nxt_f32     = !isw_ff;
              nxt_realign = isw_ff;
            end
            nxt_state = (isw_ff && bdone) ? ST_LOADW : ST_START;
          end else if (isw_ff && bdone) begin
            nxt_state = ST_LOADW;
          end
        end else if (pci_rsp_i.stop) begin
          nxt_state = ST_START; // retry resumes at the same address
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // register port next values
  always_comb begin
    nxt_cls = cls_ff;
    nxt_abort = abort_ff;
    nxt_rdata = 32'h0;
    for (int i = 0; i < NPAGE; i++) begin
      nxt_tbl[i] = tbl_ff[i];
    end
    if (reg_we_i && reg_addr_i == REG_CTRL) begin
      nxt_cls = reg_wdata_i[7:0];
    end
    if (reg_we_i && reg_addr_i == REG_STAT && reg_wdata_i[STAT_ABORT]) begin
      nxt_abort = 1'b0;
    end
    if (reg_we_i && reg_addr_i >= REG_XLAT0 && reg_addr_i <= REG_LAST) begin
      nxt_tbl[reg_addr_i[3:2]] = '{base: reg_wdata_i[31:PAGE_BITS],
                                   sp: reg_wdata_i[1:0]};
    end
    // an abort in the same cycle as the clear keeps the flag
    if (state_ff == ST_DATA && pci_rsp_i.abort) begin
      nxt_abort = 1'b1;
    end
    if (reg_re_i) begin
      if (reg_addr_i == REG_CTRL) begin
        nxt_rdata = {24'h0, cls_ff};
      end else if (reg_addr_i == REG_STAT) begin
        nxt_rdata[STAT_WPEND] = wpend_ff;
        nxt_rdata[STAT_RBUSY] = (pend_ff != 3'h0);
        nxt_rdata[STAT_ABORT] = abort_ff;
      end else if (reg_addr_i >= REG_XLAT0 && reg_addr_i <= REG_LAST) begin
        nxt_rdata = {tbl_ff[reg_addr_i[3:2]].base, {(PAGE_BITS-2){1'b0}},
                     tbl_ff[reg_addr_i[3:2]].sp};
      end
    end
  end

  // state registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      addr_ff <= 32'h0;
      end_ff <= 32'h0;
      isw_ff <= 1'b0;
      multi_ff <= 1'b0;
      span_ff <= 1'b0;
      both_ff <= 1'b0;
      be_ff <= 8'h0;
      f32_ff <= 1'b0;
      realign_ff <= 1'b0;
      wbeat_ff <= 64'h0;
      rbeat_ff <= 64'h0;
      rval_ff <= 1'b0;
      req64n_ff <= 1'b1;
      cls_ff <= CLS_RST;
      wpend_ff <= 1'b0;
      abort_ff <= 1'b0;
      pend_ff <= 3'h0;
      rdata_ff <= 32'h0;
      for (int i = 0; i < NPAGE; i++) begin
        tbl_ff[i] <= '0;
      end
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      end_ff <= nxt_end;
      isw_ff <= nxt_isw;
      multi_ff <= nxt_multi;
      span_ff <= nxt_span;
      both_ff <= nxt_both;
      be_ff <= nxt_be;
      f32_ff <= nxt_f32;
      realign_ff <= nxt_realign;
      wbeat_ff <= nxt_wbeat;
      rbeat_ff <= nxt_rbeat;
      rval_ff <= nxt_rval;
      req64n_ff <= nxt_req64n;
      cls_ff <= nxt_cls;
      wpend_ff <= nxt_wpend;
      abort_ff <= nxt_abort;
      pend_ff <= nxt_pend;
      rdata_ff <= nxt_rdata;
      for (int i = 0; i < NPAGE; i++) begin
        tbl_ff[i] <= nxt_tbl[i];
      end
    end
  end

  assign avm_readdata_o      = rbeat_ff;
  assign avm_readdatavalid_o = rval_ff;
  assign reg_rdata_o         = rdata_ff;

  // write pending flag rises the cycle after idle sees a write request
  property p_wpend;
    @(posedge mclk_i) disable iff (rst_i)
      (state_ff == ST_IDLE && avm_req_i.write) |=> wpend_ff;
  endproperty
  a_wpend: assert property (p_wpend) else $error("write pending not set");
  // a full single write never asks for 64 bits; req64_n settles after start, so
  // the width is checked at the first offered phase
  property p_wr_both;
    @(posedge mclk_i) disable iff (rst_i)
      ($rose(pci_req_o.dval) && isw_ff && !multi_ff) |-> pci_req_o.req64_n;
  endproperty
  a_wr_both: assert property (p_wr_both) else $error("single write used req64");
  // burst reads enable every byte
  property p_rd_be;
    @(posedge mclk_i) disable iff (rst_i)
      (pci_req_o.dval && !isw_ff && multi_ff) |-> (pci_req_o.be == 8'hFF);
  endproperty
  a_rd_be: assert property (p_rd_be) else $error("burst read enables");
  // outstanding delayed reads stay within the option's budget
  property p_pend;
    @(posedge mclk_i) disable iff (rst_i) pend_ff <= PLIM;
  endproperty
  a_pend: assert property (p_pend) else $error("too many reads");
  // a phase ending a page is always the last of its transaction
  property p_page;
    @(posedge mclk_i) disable iff (rst_i)
      (pci_req_o.dval && pgend) |-> pci_req_o.last;
  endproperty
  a_page: assert property (p_page) else $error("burst crossed a page");
  // long memory burst reads use read multiple
  property p_mrm;
    @(posedge mclk_i) disable iff (rst_i)
      (pci_req_o.start && !isw_ff && multi_ff && span_ff && xl.sp == SP_MEM)
      |-> (pci_req_o.cmd == CMD_MRM);
  endproperty
  a_mrm: assert property (p_mrm) else $error("read multiple not used");
  // lower-only single beat gives one narrow phase on the lower lanes;
  // checked at the first phase, since the width register loads during start
  property p_lower;
    @(posedge mclk_i) disable iff (rst_i)
      ($rose(pci_req_o.dval) && DATA64 && !multi_ff && be_ff[7:4] == 4'h0)
      |-> (pci_req_o.req64_n && pci_req_o.last && pci_req_o.be[7:4] == 4'h0);
  endproperty
  a_lower: assert property (p_lower) else $error("lower single shape");
  // status read returns the pending flag one cycle later
  property p_stat;
    @(posedge mclk_i) disable iff (rst_i)
      (reg_re_i && reg_addr_i == REG_STAT)
      |=> (reg_rdata_o[STAT_WPEND] == $past(wpend_ff));
  endproperty
  a_stat: assert property (p_stat) else $error("status read mismatch");
endmodule : atpmt_core

// ---- hdl/atpmt_pkg.sv ----
// shared constants and carrier types for the avalon to pci master translator
package atpmt_pkg;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL  = 8'h00; // cache line size in dwords
  localparam logic [7:0] REG_STAT  = 8'h04; // progress and error flags
  localparam logic [7:0] REG_XLAT0 = 8'h10; // first translation entry
  localparam logic [7:0] REG_LAST  = 8'h1C; // last translation entry
  // status bit positions
  localparam int STAT_WPEND = 0; // outbound write still pending
  localparam int STAT_RBUSY = 1; // a delayed read is outstanding
  localparam int STAT_ABORT = 2; // sticky abort, write one to clear
  // reset values
  localparam logic [7:0] CLS_RST = 8'h08;
  // pci command codes
  localparam logic [3:0] CMD_IORD  = 4'h2;
  localparam logic [3:0] CMD_IOWR  = 4'h3;
  localparam logic [3:0] CMD_MRD   = 4'h6;
  localparam logic [3:0] CMD_MWR   = 4'h7;
  localparam logic [3:0] CMD_CFGRD = 4'hA;
  localparam logic [3:0] CMD_CFGWR = 4'hB;
  localparam logic [3:0] CMD_MRM   = 4'hC;
  // address spaces held in a translation entry
  localparam logic [1:0] SP_MEM = 2'h0;
  localparam logic [1:0] SP_IO  = 2'h1;
  localparam logic [1:0] SP_CFG = 2'h2;
  // limits
  localparam logic [7:0] MAX_BURST = 8'h80; // largest burst count
  localparam logic [2:0] MULTI_LIM = 3'h4;  // delayed reads in multi mode
  localparam logic [2:0] SINGLE_LIM = 3'h1; // delayed reads in single mode
  // avalon request, held stable by the master while waitrequest is high
  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] addr;
    logic [7:0]  burst;
    logic [7:0]  be;
    logic [63:0] wdata;
  } atpmt_avm_req_t;
  // request toward the pci bus engine
  typedef struct packed {
    logic        start;   // one cycle, opens a transaction
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic        req64_n; // low asks for 64-bit phases
    logic        dval;    // a data phase is offered
    logic        last;    // offered phase is the final one
    logic [7:0]  be;      // active high byte enables
    logic [63:0] wdata;
  } atpmt_pci_req_t;
  // answer from the pci bus engine
  typedef struct packed {
    logic        phase;   // offered data phase completed
    logic        ack64_n; // low when the target took 64 bits
    logic        stop;    // transaction ended by the target
    logic        abort;   // master or target abort
    logic [63:0] rdata;
  } atpmt_pci_rsp_t;
endpackage : atpmt_pkg
